// >>> dacrc_regs.sv
// Full-scale resistor control and self-calibration registers for DAC channels 1 and 2
//
// Overview of operation
// - Bit 15 enables the channel's internal resistor; reads back its in-use state.
// - Bits 12:8 hold the read-only calibrated resistor code, reset zero, write-proof.
// - Bits 4:0 hold the writable resistor code, resetting to 0x0A.
// - Bits 14 and 13 flag comparator offset calibration overflow and underflow.
// - Bits 12..9 flag resistor and gain calibration overflow/underflow; reset clear.
// - Writing bit 8 high then low clears all stored calibration results.
// - Bit 7 reports calibration values in use; zero after reset.
// - Bit 6 enables gain calibration; when clear manual gains are used.
// - Bit 3 gates the calibration clock; clear means calibration logic stalls.
// - Bits 2:0 pick the DAC-clock divider for the calibration clock; reset zero.
// - A start request runs one calibration sequence on the gated clock.
// - A finished calibration sets a completion flag, driven out on calDoneFlag and not readable in any register.
`timescale 1ns/1ps
`default_nettype none
module dacrc_regs #(
  parameter int STEPS = 8
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              regWr,
  input  wire logic              regRd,
  input  wire logic [7:0]        regAddr,
  input  wire logic [15:0]       regWdata,
  output logic      [15:0]       regRdata,
  input  wire logic              calStart,
  input  wire logic signed [5:0] ch1Meas,
  input  wire logic signed [5:0] ch2Meas,
  input  wire logic signed [7:0] gainMeas,
  input  wire logic signed [7:0] offsetMeas,
  output logic                   ch1RsetEnable,
  output logic                   ch2RsetEnable,
  output logic      [4:0]        ch1RsetCode,
  output logic      [4:0]        ch2RsetCode,
  output logic                   gainCalEnable,
  output logic      [6:0]        gainCalCode,
  output logic      [6:0]        compOffsetCode,
  output logic      [1:0]        offsetCalRange,
  output logic                   calClkTick,
  output logic                   calBusy,
  output logic                   calDoneFlag
);

  // Resistor code plus signed measurement, clamped to 0..31: {ov, uf, code}
  function automatic logic [6:0] satU5(input logic [4:0] base, input logic signed [5:0] d);
    logic signed [7:0] s;
    s = $signed({3'b000, base}) + 8'(d);
    if (s > $signed({3'b000, dacrc_pkg::RSET_MAX})) satU5 = {2'b10, dacrc_pkg::RSET_MAX};
    else if (s < 8'sh00) satU5 = {2'b01, 5'h00};
    else satU5 = {2'b00, s[4:0]};
  endfunction

  // Signed 8-bit measurement clamped to the signed 7-bit range: {ov, uf, code}
  function automatic logic [8:0] satS7(input logic signed [7:0] v);
    if (v > dacrc_pkg::S7_MAX) satS7 = {2'b10, dacrc_pkg::S7_MAX[6:0]};
    else if (v < dacrc_pkg::S7_MIN) satS7 = {2'b01, dacrc_pkg::S7_MIN[6:0]};
    else satS7 = {2'b00, v[6:0]};
  endfunction

  // Software-visible and internal state
  logic       en1, en2, calEn, clkEn, calRstBit;
  logic [4:0] code1, code2, cal1, cal2;
  logic [1:0] range;
  logic [2:0] div;
  logic [5:0] flags;  // {compOf, compUf, rsetOf, rsetUf, gainOf, gainUf}
  logic       calMode, done;
  logic [6:0] gainRes, offRes;
  logic [15:0] rdata;
  logic [2:0] divCnt;
  logic       tick;
  logic [3:0] stepCnt;
  dacrc_pkg::dacrc_state_t state;

  logic       next_en1, next_en2, next_calEn, next_clkEn, next_calRstBit;
  logic [4:0] next_code1, next_code2, next_cal1, next_cal2;
  logic [1:0] next_range;
  logic [2:0] next_div, next_divCnt;
  logic [5:0] next_flags;
  logic       next_calMode, next_done, next_tick;
  logic [6:0] next_gainRes, next_offRes;
  logic [15:0] next_rdata;
  logic [3:0] next_stepCnt;
  dacrc_pkg::dacrc_state_t next_state;
  logic       calClear, finish;
  logic [6:0] r1, r2;
  logic [8:0] g, o;

  // Saturated results of the current measurements
  assign r1 = satU5(code1, ch1Meas);
  assign r2 = satU5(code2, ch2Meas);
  assign g  = satS7(gainMeas);
  assign o  = satS7(offsetMeas);

  // Calibration clock divider: one tick every div+1 DAC clocks, only while gated on
  always_comb begin
    next_divCnt = divCnt;
    next_tick   = 1'b0;
    if (!clkEn) begin
      next_divCnt = 3'h0;
    end else if (divCnt >= div) begin
      next_divCnt = 3'h0;
      next_tick   = 1'b1;
    end else begin
      next_divCnt = divCnt + 3'h1;
    end
  end

  // Counter parks at zero while gated, so reopening the gate starts a fresh period
  always_ff @(posedge clk) begin
    if (!rstn) begin
      divCnt <= 3'h0;
      tick   <= 1'b0;
    end else begin
      divCnt <= next_divCnt;
      tick   <= next_tick;
    end
  end

  // Sequencer steps through RUN only on calibration clock ticks, so a gated clock stalls it
  always_comb begin
    next_state   = state;
    next_stepCnt = stepCnt;
    finish       = 1'b0;
    unique case (state)
      dacrc_pkg::DACRC_IDLE: begin
        if (calStart) begin
          next_state   = dacrc_pkg::DACRC_RUN;
          next_stepCnt = 4'h0;
        end
      end
      dacrc_pkg::DACRC_RUN: begin
        if (tick) begin
          if (stepCnt == 4'(STEPS - 1)) begin
            next_state = dacrc_pkg::DACRC_DONE;
            finish     = 1'b1;
          end else begin
            next_stepCnt = stepCnt + 4'h1;
          end
        end
      end
      dacrc_pkg::DACRC_DONE: begin
        next_state = dacrc_pkg::DACRC_IDLE;
      end
      default: next_state = dacrc_pkg::DACRC_IDLE;
    endcase
  end

  // Sequencer state and step count
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state   <= dacrc_pkg::DACRC_IDLE;
      stepCnt <= 4'h0;
    end else begin
      state   <= next_state;
      stepCnt <= next_stepCnt;
    end
  end

  // Register writes, result capture and read data
  always_comb begin
    next_en1 = en1;
    next_en2 = en2;
    next_code1 = code1;
    next_code2 = code2;
    next_calEn = calEn;
    next_clkEn = clkEn;
    next_range = range;
    next_div = div;
    next_calRstBit = calRstBit;
    if (regWr) begin
      unique case (regAddr)
        dacrc_pkg::CH1_RES_ADDR: begin
          next_en1   = regWdata[dacrc_pkg::RSET_EN_BIT];
          next_code1 = regWdata[dacrc_pkg::RSET_CODE_LSB +: dacrc_pkg::RSET_W];
        end
        dacrc_pkg::CH2_RES_ADDR: begin
          next_en2   = regWdata[dacrc_pkg::RSET_EN_BIT];
          next_code2 = regWdata[dacrc_pkg::RSET_CODE_LSB +: dacrc_pkg::RSET_W];
        end
        dacrc_pkg::CAL_CFG_ADDR: begin
          next_calRstBit = regWdata[dacrc_pkg::CAL_RST_BIT];
          next_calEn     = regWdata[dacrc_pkg::CAL_EN_BIT];
          next_range     = regWdata[dacrc_pkg::RANGE_LSB +: 2];
          next_clkEn     = regWdata[dacrc_pkg::CLK_EN_BIT];
          next_div       = regWdata[dacrc_pkg::DIV_LSB +: 3];
        end
        default: ;
      endcase
    end
    // Results clear on the falling edge of the reset bit, i.e. after a full high-low pulse
    calClear = calRstBit && !next_calRstBit;
    next_cal1 = calClear ? dacrc_pkg::RSET_CAL_RST : cal1;
    next_cal2 = calClear ? dacrc_pkg::RSET_CAL_RST : cal2;
    next_gainRes = calClear ? 7'h00 : gainRes;
    next_offRes = calClear ? 7'h00 : offRes;
    next_flags = calClear ? 6'h00 : flags;
    next_calMode = calClear ? 1'b0 : calMode;
    next_done = calClear ? 1'b0 : done;
    if (calStart && state == dacrc_pkg::DACRC_IDLE) begin
      next_done = 1'b0;
    end
    // Capture wins over a coincident clear so a finishing calibration is never lost
    if (finish) begin
      next_cal1    = r1[4:0];
      next_cal2    = r2[4:0];
      next_offRes  = o[6:0];
      next_gainRes = calEn ? g[6:0] : gainRes;
      next_flags   = next_flags | {o[8:7], r1[6:5] | r2[6:5],
                                   calEn ? g[8:7] : 2'b00};
      next_calMode = 1'b1;
      next_done    = 1'b1;
    end
    // Read word is registered here and again at the output; it stands for one cycle
    next_rdata = 16'h0000;
    if (regRd) begin
      unique case (regAddr)
        dacrc_pkg::CH1_RES_ADDR: next_rdata = {en1, 2'b00, cal1, 3'b000, code1};
        dacrc_pkg::CH2_RES_ADDR: next_rdata = {en2, 2'b00, cal2, 3'b000, code2};
        dacrc_pkg::CAL_CFG_ADDR:
          next_rdata = {1'b0, flags, calRstBit, calMode, calEn, range, clkEn, div};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // Register bank; reserved bits have no storage behind them and read as zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      en1 <= 1'b0;
      en2 <= 1'b0;
      code1 <= dacrc_pkg::RSET_CODE_RST;
      code2 <= dacrc_pkg::RSET_CODE_RST;
      cal1 <= dacrc_pkg::RSET_CAL_RST;
      cal2 <= dacrc_pkg::RSET_CAL_RST;
      calEn <= 1'b0;
      clkEn <= 1'b0;
      range <= dacrc_pkg::RANGE_RST;
      div <= dacrc_pkg::DIV_RST;
      calRstBit <= 1'b0;
      flags <= 6'h00;
      calMode <= 1'b0;
      done <= 1'b0;
      gainRes <= 7'h00;
      offRes <= 7'h00;
      rdata <= 16'h0000;
    end else begin
      en1 <= next_en1;
      en2 <= next_en2;
      code1 <= next_code1;
      code2 <= next_code2;
      cal1 <= next_cal1;
      cal2 <= next_cal2;
      calEn <= next_calEn;
      clkEn <= next_clkEn;
      range <= next_range;
      div <= next_div;
      calRstBit <= next_calRstBit;
      flags <= next_flags;
      calMode <= next_calMode;
      done <= next_done;
      gainRes <= next_gainRes;
      offRes <= next_offRes;
      rdata <= next_rdata;
    end
  end

  // Outputs: calibrated codes drive the resistors only once calibration values are in use
  always_ff @(posedge clk) begin
    if (!rstn) begin
      regRdata       <= 16'h0000;
      ch1RsetEnable  <= 1'b0;
      ch2RsetEnable  <= 1'b0;
      ch1RsetCode    <= dacrc_pkg::RSET_CODE_RST;
      ch2RsetCode    <= dacrc_pkg::RSET_CODE_RST;
      gainCalEnable  <= 1'b0;
      gainCalCode    <= 7'h00;
      compOffsetCode <= 7'h00;
      offsetCalRange <= dacrc_pkg::RANGE_RST;
      calClkTick     <= 1'b0;
      calBusy        <= 1'b0;
      calDoneFlag    <= 1'b0;
    end else begin
      regRdata       <= rdata;
      ch1RsetEnable  <= en1;
      ch2RsetEnable  <= en2;
      ch1RsetCode    <= (calMode && en1) ? cal1 : code1;
      ch2RsetCode    <= (calMode && en2) ? cal2 : code2;
      gainCalEnable  <= calEn;
      gainCalCode    <= gainRes;
      compOffsetCode <= offRes;
      offsetCalRange <= range;
      calClkTick     <= tick;
      calBusy        <= (state == dacrc_pkg::DACRC_RUN);
      calDoneFlag    <= done;
    end
  end

endmodule
`default_nettype wire

// >>> dacrc_pkg.sv
// Register map, field layout, reset values and timing constants of the resistor/calibration block
package dacrc_pkg;
  // Register addresses on the configuration register port
  localparam logic [7:0] CH2_RES_ADDR = 8'h0b;
  localparam logic [7:0] CH1_RES_ADDR = 8'h0c;
  localparam logic [7:0] CAL_CFG_ADDR = 8'h0d;

  // Resistor control register fields
  localparam int RSET_EN_BIT   = 15;
  localparam int RSET_CAL_LSB  = 8;
  localparam int RSET_CODE_LSB = 0;
  localparam int RSET_W        = 5;
  localparam logic [4:0] RSET_CODE_RST = 5'h0a;
  localparam logic [4:0] RSET_CAL_RST  = 5'h00;
  localparam logic [4:0] RSET_MAX      = 5'h1f;

  // Calibration configuration fields
  localparam int COMP_OF_BIT   = 14;
  localparam int COMP_UF_BIT   = 13;
  localparam int RSET_OF_BIT   = 12;
  localparam int RSET_UF_BIT   = 11;
  localparam int GAIN_OF_BIT   = 10;
  localparam int GAIN_UF_BIT   = 9;
  localparam int CAL_RST_BIT   = 8;
  localparam int CAL_MODE_BIT  = 7;
  localparam int CAL_EN_BIT    = 6;
  localparam int RANGE_LSB     = 4;
  localparam int CLK_EN_BIT    = 3;
  localparam int DIV_LSB       = 0;
  localparam logic [2:0] DIV_RST   = 3'h0;
  localparam logic [1:0] RANGE_RST = 2'h0;

  // Signed 7-bit result limits for gain and comparator offset
  localparam logic signed [7:0] S7_MAX = 8'sh3f;
  localparam logic signed [7:0] S7_MIN = -8'sh40;

  // Calibration clock ticks spent settling before results are captured
  localparam logic [3:0] CAL_STEPS = 4'h8;

  // Calibration sequencer states, one-hot
  typedef enum logic [2:0] {
    DACRC_IDLE = 3'b001,
    DACRC_RUN  = 3'b010,
    DACRC_DONE = 3'b100
  } dacrc_state_t;
endpackage

// >>> dacrc_regs_sva.sv
// Assertion checker watching the resistor and calibration block ports
`timescale 1ns/1ps
`default_nettype none
module dacrc_regs_sva #(
  parameter int STEPS = 8
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regRdata,
  input wire logic        calStart,
  input wire logic        ch1RsetEnable,
  input wire logic [4:0]  ch1RsetCode,
  input wire logic        gainCalEnable,
  input wire logic        calClkTick,
  input wire logic        calBusy,
  input wire logic        calDoneFlag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [5:0] tickCnt;
  logic [5:0] next_tickCnt;
  // Ticks in one run; busy and tick lag alike, so exactly STEPS land before busy drops
  always_comb begin
    next_tickCnt = calBusy ? tickCnt + {5'h00, calClkTick} : 6'h00;
  end
  always_ff @(posedge clk) begin
    tickCnt <= rstn ? next_tickCnt : 6'h00;
  end
  a_enable_after_write: assert property (
    $changed(ch1RsetEnable) |-> $past(regWr) || $past(regWr, 2))
    else $error("resistor enable moved without a write");
  a_reserved_read_zero: assert property (
    regRd && regAddr == dacrc_pkg::CH1_RES_ADDR |->
      ##2 regRdata[14:13] == 2'h0 && regRdata[7:5] == 3'h0)
    else $error("reserved resistor bits read nonzero");
  a_code_has_cause: assert property (
    $changed(ch1RsetCode) |-> $past(regWr) || $past(regWr, 2) || $past(calBusy)
      || $past(calBusy, 2) || $past(calBusy, 3))
    else $error("resistor code moved without cause");
  a_start_runs: assert property (
    calStart && !calBusy && !calDoneFlag |-> ##[1:3] calBusy)
    else $error("idle start did not run");
  a_tick_count_bound: assert property (
    tickCnt <= STEPS + 2)
    else $error("run used too many ticks");
  a_finish_on_tick: assert property (
    $fell(calBusy) |-> $past(calClkTick) || $past(calClkTick, 2) || $past(calClkTick, 3))
    else $error("run ended without a tick");
  a_done_follows_run: assert property (
    $fell(calBusy) |-> ##[0:3] calDoneFlag)
    else $error("completion flag late");
  a_done_holds_flag: assert property (
    $fell(calDoneFlag) |-> $past(regWr) || $past(regWr, 2) || $past(calStart)
      || $past(calStart, 2))
    else $error("completion flag dropped by itself");
  a_gain_enable_write: assert property (
    $changed(gainCalEnable) |-> $past(regWr) || $past(regWr, 2))
    else $error("gain enable moved without a write");
  c_cal_done: cover property ($rose(calDoneFlag));
  c_stalled_run: cover property ((calBusy && !calClkTick) [*8]);
  c_cfg_read: cover property (regRd && regAddr == dacrc_pkg::CAL_CFG_ADDR);
endmodule
bind dacrc_regs dacrc_regs_sva #(.STEPS(STEPS)) chk (
  .clk(clk), .rstn(rstn), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
  .regRdata(regRdata), .calStart(calStart), .ch1RsetEnable(ch1RsetEnable),
  .ch1RsetCode(ch1RsetCode), .gainCalEnable(gainCalEnable), .calClkTick(calClkTick),
  .calBusy(calBusy), .calDoneFlag(calDoneFlag));
`default_nettype wire

// >>> dacrc_regs_bench.sv
// Self-checking bench for the resistor and calibration register block
`timescale 1ns/1ps
`default_nettype none
module dacrc_regs_bench;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  logic [7:0]        regAddr = 8'h00;
  logic [15:0]       regWdata = 16'h0000;
  logic              calStart = 1'b0;
  logic signed [5:0] ch1Meas = 6'sh1f;
  logic signed [5:0] ch2Meas = -6'sh08;
  logic signed [7:0] gainMeas = 8'sh7f;
  logic signed [7:0] offsetMeas = -8'sh80;
  logic [15:0]       regRdata;
  logic              en1, en2, gEn, tick, calBusy, calDoneFlag;
  logic [4:0]        code1, code2;
  logic [6:0]        gCode, oCode;
  logic [1:0]        rng;
  int                failures = 0;
  int                comparisons = 0;
  int                n;
  always #2 clk = ~clk;
  dacrc_regs #(.STEPS(8)) uut (
    .clk(clk), .rstn(rstn), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .calStart(calStart), .ch1Meas(ch1Meas),
    .ch2Meas(ch2Meas), .gainMeas(gainMeas), .offsetMeas(offsetMeas), .ch1RsetEnable(en1),
    .ch2RsetEnable(en2), .ch1RsetCode(code1), .ch2RsetCode(code2), .gainCalEnable(gEn),
    .gainCalCode(gCode), .compOffsetCode(oCode), .offsetCalRange(rng), .calClkTick(tick),
    .calBusy(calBusy), .calDoneFlag(calDoneFlag));
  task automatic complete_run();
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobes rise and fall on falling edges, so each request spans one rising edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    regWr = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clk);
    regWr = 1'b0;
  endtask
  // Read data appears at the edge after the taking edge and stands for one cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge clk);
    regRd = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRd = 1'b0;
    @(negedge clk);
    check(regRdata, e);
  endtask
  task automatic start_and_wait();
    @(negedge clk);
    calStart = 1'b1;
    @(negedge clk);
    calStart = 1'b0;
    for (n = 1; n < 300 && calDoneFlag !== 1'b1; n++) @(negedge clk);
    if (n == 300) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic t_reset_values();
    rd(8'h0c, 16'h000a);
    rd(8'h0b, 16'h000a);
    rd(8'h0d, 16'h0000);
    rd(8'h0e, 16'h0000);
  endtask
  // Read-only and reserved bits must ignore an all-ones write
  task automatic t_writes();
    wr(8'h0c, 16'hffff);
    rd(8'h0c, 16'h801f);
    check({15'h0, en1}, 16'h0001);
    wr(8'h0b, 16'h8001);
    rd(8'h0b, 16'h8001);
    check({15'h0, en2}, 16'h0001);
    wr(8'h0d, 16'h0030);
    rd(8'h0d, 16'h0030);
    check({14'h0, rng}, 16'h0003);
    wr(8'h0d, 16'h7ec9);
    rd(8'h0d, 16'h0049);
    check({15'h0, gEn}, 16'h0001);
  endtask
  // Every result out of range, divide by two, so the run needs twice the clocks
  task automatic t_saturating_run();
    start_and_wait();
    check({15'h0, n >= 16}, 16'h0001);
    rd(8'h0d, 16'h3cc9);
    rd(8'h0c, 16'h9f1f);
    rd(8'h0b, 16'h8001);
    check({6'h0, code1, code2}, 16'h03e0);
    check({2'h0, gCode, oCode}, 16'h1fc0);
  endtask
  task automatic t_cal_reset();
    wr(8'h0d, 16'h0149);
    wr(8'h0d, 16'h0049);
    rd(8'h0d, 16'h0049);
    rd(8'h0c, 16'h801f);
    check({15'h0, calDoneFlag}, 16'h0000);
  endtask
  // A run with the clock gated off must stall, then finish once it is let through
  task automatic t_gated_run();
    wr(8'h0d, 16'h0000);
    @(negedge clk);
    calStart = 1'b1;
    @(negedge clk);
    calStart = 1'b0;
    repeat (40) @(negedge clk);
    check({14'h0, calBusy, calDoneFlag}, 16'h0002);
    check({15'h0, tick}, 16'h0000);
    wr(8'h0d, 16'h0008);
    for (n = 1; n < 300 && calDoneFlag !== 1'b1; n++) @(negedge clk);
    check({15'h0, calDoneFlag}, 16'h0001);
    check({15'h0, tick}, 16'h0001);
    rd(8'h0d, 16'h3888);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    t_reset_values();
    t_writes();
    t_saturating_run();
    t_cal_reset();
    t_gated_run();
    complete_run();
  end
endmodule
`default_nettype wire
